/* shared/fsw_pkg.sv */
// Shared constants, types and layouts for the flash status and write-protect block
package fsw_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int STATUS_WRITE_NS = 100;
   localparam int STATUS_WRITE_CYCLES_I = (STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAIT_W = 8;
   localparam logic [WAIT_W-1:0] STATUS_WRITE_CYCLES = WAIT_W'(STATUS_WRITE_CYCLES_I);

   // ------------------------------------------------------------
   // Array map: 4 KB sectors, 64 KB blocks, 512 KB array
   // ------------------------------------------------------------
   localparam int ADDR_W = 24;
   localparam int ARRAY_ADDR_W = 19;
   localparam int SECTOR_SHIFT = 12;
   localparam int BLOCK_SHIFT = 16;
   localparam int SECTOR_W = ARRAY_ADDR_W - SECTOR_SHIFT;
   localparam int BLOCK_W = ARRAY_ADDR_W - BLOCK_SHIFT;
   localparam logic [BLOCK_W-1:0] BLOCK_TOP = 3'h7;
   localparam logic [BLOCK_W-1:0] BLOCK_UPPER_QUARTER = 3'h6;
   localparam logic [BLOCK_W-1:0] BLOCK_UPPER_HALF = 3'h4;

   // ------------------------------------------------------------
   // Protect bit codes
   // ------------------------------------------------------------
   localparam logic [2:0] PROTECT_NONE = 3'h0;
   localparam logic [2:0] PROTECT_TOP_BLOCK = 3'h1;
   localparam logic [2:0] PROTECT_QUARTER = 3'h2;
   localparam logic [2:0] PROTECT_HALF = 3'h3;

   // ------------------------------------------------------------
   // Serial framing and instruction codes
   // ------------------------------------------------------------
   localparam int BIT_CNT_W = 12;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_MAX = 12'hfff;
   localparam logic [BIT_CNT_W-1:0] BITS_OPCODE_LAST = 12'h007;
   localparam logic [BIT_CNT_W-1:0] BITS_DATA_LAST = 12'h00f;
   localparam logic [BIT_CNT_W-1:0] BITS_ADDR_LAST = 12'h01f;
   localparam logic [BIT_CNT_W-1:0] BYTES_ONE = 12'h001;
   localparam logic [BIT_CNT_W-1:0] BYTES_STATUS = 12'h002;
   localparam logic [BIT_CNT_W-1:0] BYTES_ERASE = 12'h004;
   localparam logic [BIT_CNT_W-1:0] BYTES_PROGRAM_MIN = 12'h005;
   localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
   localparam logic [7:0] READ_STATUS_CMD = 8'h05;
   localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;
   localparam logic [7:0] PROGRAM_CMD = 8'h02;
   localparam logic [7:0] SECTOR_ERASE_CMD = 8'hd7;
   localparam logic [7:0] SECTOR_ERASE_ALT_CMD = 8'h20;
   localparam logic [7:0] BLOCK_ERASE_CMD = 8'hd8;
   localparam logic [7:0] WHOLE_ARRAY_ERASE_CMD = 8'hc7;
   localparam logic [7:0] WHOLE_ARRAY_ERASE_ALT_CMD = 8'h60;

   // ------------------------------------------------------------
   // Status register layout, reset value 0x00
   // ------------------------------------------------------------
   typedef struct packed {
      logic status_lock_bit;
      logic [1:0] reserved;
      logic [2:0] protect_bits;
      logic write_enable_latch;
      logic busy_flag;
   } fsw_status_s;

   localparam logic [7:0] STATUS_RESET = 8'h00;

   // Array operation handed to the program/erase engine
   typedef enum logic [1:0] {
      OP_PROGRAM = 2'h0,
      OP_SECTOR_ERASE = 2'h1,
      OP_BLOCK_ERASE = 2'h2,
      OP_WHOLE_ERASE = 2'h3
   } fsw_array_op_e;

   typedef struct packed {
      fsw_array_op_e op;
      logic [ADDR_W-1:0] addr;
      logic [SECTOR_W-1:0] sector;
      logic [BLOCK_W-1:0] block;
   } fsw_array_req_s;

   // Engine state
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_STATUS_WRITE = 3'b010,
      ST_ARRAY_BUSY = 3'b100
   } fsw_state_e;

endpackage : fsw_pkg

/* verilog/fsw_sync.sv */
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module fsw_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   // ------------------------------------------------------------
   // One pair of flops per bit
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic stage1;
         // First stage feeds only the second
         always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               stage1 <= RESET_VAL[g];
               o_sync[g] <= RESET_VAL[g];
            end else begin
               stage1 <= i_async[g];
               o_sync[g] <= stage1;
            end
         end
      end
   endgenerate

endmodule : fsw_sync

/* verilog/fsw_protect_decode.sv */
// Decodes the protect bits against a target address
`timescale 1ns/1ps
module fsw_protect_decode (
   input wire logic [2:0] i_protect_bits,
   input wire logic [fsw_pkg::ADDR_W-1:0] i_addr,
   output logic o_protected
);
   import fsw_pkg::*;

   logic [BLOCK_W-1:0] block;

   // Block index of the target
   assign block = i_addr[ARRAY_ADDR_W-1:BLOCK_SHIFT];

   // Protected region selected by the three protect bits
   always_comb begin
      if (i_protect_bits[2]) begin
         o_protected = 1'b1;
      end else begin
         unique case (i_protect_bits)
            PROTECT_NONE: o_protected = 1'b0;
            PROTECT_TOP_BLOCK: o_protected = (block == BLOCK_TOP);
            PROTECT_QUARTER: o_protected = (block >= BLOCK_UPPER_QUARTER);
            PROTECT_HALF: o_protected = (block >= BLOCK_UPPER_HALF);
            default: o_protected = 1'b1;
         endcase
      end
   end

endmodule : fsw_protect_decode

/* verilog/fsw_status_protect.sv */
// Status register, write-enable latch and write protection of a serial flash
//
// Functional notes
// - Array is eight 64 KB blocks of sixteen 4 KB sectors each.
// - Lock and protect bits change only through the write-status instruction.
// - Read-status instruction returns the eight status bits on serial output.
// - Busy flag in bit 0 is one while a write operation runs.
// - Cleared write-enable latch blocks status writes, programs and all erases.
// - Latch clears on write-disable and when any write operation completes.
// - Protect codes select none, block 7, blocks 6-7, 4-7, or all.
// - Program or erase aimed inside the protected region is refused.
// - Whole-array erase runs only when all protect bits are zero.
// - Lock bit set with protect pin low makes status writes ignored.
// - Lock bit clear or protect pin high lets status writes update bits.
// - Layout: lock 7, zero 6-5, protect 4-2, latch 1, busy 0.
// - Protect and lock bits start at zero: nothing protected, unlocked.
// - Input sampled on rising serial clock, output changed on falling.
// - Instructions, addresses and data travel most significant bit first.
// - Write instructions with a bit count not a multiple of eight are ignored.
`timescale 1ns/1ps
module fsw_status_protect (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic i_spi_sck,
   input wire logic i_spi_ce_n,
   input wire logic i_serial_data_io,
   input wire logic i_write_protect_n,
   input wire logic i_array_done,
   output logic o_serial_out,
   output logic o_serial_out_oe,
   output logic o_array_start,
   output fsw_pkg::fsw_array_req_s o_array_req,
   output fsw_pkg::fsw_status_s o_status
);
   import fsw_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisation and edge detection
   // ------------------------------------------------------------
   logic [3:0] pin_sync;
   logic sck_s;
   logic ce_n_s;
   logic si_s;
   logic wp_n_s;
   logic sck_d;
   logic ce_n_d;
   logic sck_rise;
   logic sck_fall;
   logic frame_start;
   logic frame_end;

   fsw_sync #(.WIDTH(4), .RESET_VAL(4'b1110)) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_reset_n(i_reset_n),
      .i_async({i_write_protect_n, i_serial_data_io, i_spi_ce_n, i_spi_sck}),
      .o_sync(pin_sync)
   );

   assign {wp_n_s, si_s, ce_n_s, sck_s} = pin_sync;

   // Delayed copies for edges
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sck_d <= 1'b0;
         ce_n_d <= 1'b1;
      end else begin
         sck_d <= sck_s;
         ce_n_d <= ce_n_s;
      end
   end

   assign sck_rise = sck_s & ~sck_d & ~ce_n_s;
   assign sck_fall = ~sck_s & sck_d & ~ce_n_s;
   assign frame_start = ~ce_n_s & ce_n_d;
   assign frame_end = ce_n_s & ~ce_n_d;

   // ------------------------------------------------------------
   // Serial input shifter
   // ------------------------------------------------------------
   logic [BIT_CNT_W-1:0] bit_cnt;
   logic [7:0] shift_in;
   logic [7:0] next_byte;
   logic [7:0] opcode;
   logic [7:0] status_data;
   logic [ADDR_W-1:0] addr;

   assign next_byte = {shift_in[6:0], si_s};

   // Bit counter, saturating for long program frames
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bit_cnt <= '0;
         shift_in <= '0;
      end else if (frame_start) begin
         bit_cnt <= '0;
      end else if (sck_rise) begin
         shift_in <= next_byte;
         if (bit_cnt != BIT_CNT_MAX) begin
            bit_cnt <= bit_cnt + 1'b1;
         end
      end
   end

   // Byte captures: opcode, status data byte, address
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         opcode <= '0;
         status_data <= '0;
         addr <= '0;
      end else if (sck_rise) begin
         if (bit_cnt == BITS_OPCODE_LAST) begin
            opcode <= next_byte;
         end
         if (bit_cnt == BITS_DATA_LAST) begin
            status_data <= next_byte;
         end
         if (bit_cnt > BITS_OPCODE_LAST && bit_cnt <= BITS_ADDR_LAST) begin
            addr <= {addr[ADDR_W-2:0], si_s};
         end
      end
   end

   // ------------------------------------------------------------
   // Status state and frame decisions
   // ------------------------------------------------------------
   fsw_state_e state;
   logic write_enable_latch;
   logic busy_flag;
   logic [2:0] protect_bits;
   logic status_lock_bit;
   logic [WAIT_W-1:0] wait_cnt;
   fsw_status_s status_now;
   logic [BIT_CNT_W-1:0] byte_cnt;
   logic whole_bytes;
   logic addr_protected;
   logic status_locked;
   logic may_write;
   logic is_sector_erase;
   logic is_whole_erase;
   logic accept_status;
   logic accept_program;
   logic accept_erase;
   logic accept_whole;
   logic accept_array;

   fsw_protect_decode u_protect (
      .i_protect_bits(protect_bits),
      .i_addr(addr),
      .o_protected(addr_protected)
   );

   assign status_now = '{status_lock_bit: status_lock_bit, reserved: 2'b00,
                         protect_bits: protect_bits, write_enable_latch: write_enable_latch,
                         busy_flag: busy_flag};
   assign byte_cnt = bit_cnt >> 3;
   assign whole_bytes = (bit_cnt[2:0] == 3'h0);
   assign status_locked = status_lock_bit & ~wp_n_s;
   assign may_write = frame_end & whole_bytes & write_enable_latch & ~busy_flag;
   assign is_sector_erase = (opcode == SECTOR_ERASE_CMD) || (opcode == SECTOR_ERASE_ALT_CMD);
   assign is_whole_erase = (opcode == WHOLE_ARRAY_ERASE_CMD)
                        || (opcode == WHOLE_ARRAY_ERASE_ALT_CMD);
   assign accept_status = may_write && opcode == WRITE_STATUS_CMD
                       && byte_cnt >= BYTES_STATUS && !status_locked;
   assign accept_program = may_write && opcode == PROGRAM_CMD
                        && byte_cnt >= BYTES_PROGRAM_MIN && !addr_protected;
   assign accept_erase = may_write && (is_sector_erase || opcode == BLOCK_ERASE_CMD)
                      && byte_cnt == BYTES_ERASE && !addr_protected;
   assign accept_whole = may_write && is_whole_erase && byte_cnt == BYTES_ONE
                      && protect_bits == PROTECT_NONE;
   assign accept_array = accept_program | accept_erase | accept_whole;

   // Engine sequence: idle, status write timer, array wait
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= ST_IDLE;
         wait_cnt <= '0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               wait_cnt <= '0;
               if (accept_status) begin
                  state <= ST_STATUS_WRITE;
               end else if (accept_array) begin
                  state <= ST_ARRAY_BUSY;
               end
            end
            ST_STATUS_WRITE: begin
               wait_cnt <= wait_cnt + 1'b1;
               if (wait_cnt == STATUS_WRITE_CYCLES - 1'b1) begin
                  state <= ST_IDLE;
               end
            end
            ST_ARRAY_BUSY: begin
               if (i_array_done) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Busy flag follows accepted operations
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         busy_flag <= 1'b0;
      end else if (accept_status || accept_array) begin
         busy_flag <= 1'b1;
      end else if ((state == ST_STATUS_WRITE && wait_cnt == STATUS_WRITE_CYCLES - 1'b1)
                   || (state == ST_ARRAY_BUSY && i_array_done)) begin
         busy_flag <= 1'b0;
      end
   end

   // Write-enable latch: set, cleared by command or completion
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         write_enable_latch <= 1'b0;
      end else if ((state == ST_STATUS_WRITE && wait_cnt == STATUS_WRITE_CYCLES - 1'b1)
                   || (state == ST_ARRAY_BUSY && i_array_done)) begin
         write_enable_latch <= 1'b0;
      end else if (frame_end && !busy_flag && byte_cnt == BYTES_ONE && whole_bytes) begin
         if (opcode == WRITE_ENABLE_CMD) begin
            write_enable_latch <= 1'b1;
         end else if (opcode == WRITE_DISABLE_CMD) begin
            write_enable_latch <= 1'b0;
         end
      end
   end

   // Lock and protect bits, written only by an accepted status write
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         protect_bits <= PROTECT_NONE;
         status_lock_bit <= 1'b0;
      end else if (accept_status) begin
         protect_bits <= status_data[4:2];
         status_lock_bit <= status_data[7];
      end
   end

   // Array request toward the program/erase engine
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_array_start <= 1'b0;
         o_array_req <= '0;
      end else begin
         o_array_start <= accept_array;
         if (accept_array) begin
            o_array_req.addr <= addr;
            o_array_req.sector <= addr[ARRAY_ADDR_W-1:SECTOR_SHIFT];
            o_array_req.block <= addr[ARRAY_ADDR_W-1:BLOCK_SHIFT];
            if (accept_whole) begin
               o_array_req.op <= OP_WHOLE_ERASE;
            end else if (accept_program) begin
               o_array_req.op <= OP_PROGRAM;
            end else if (is_sector_erase) begin
               o_array_req.op <= OP_SECTOR_ERASE;
            end else begin
               o_array_req.op <= OP_BLOCK_ERASE;
            end
         end
      end
   end

   // Status mirror
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_status <= STATUS_RESET;
      end else begin
         o_status <= status_now;
      end
   end

   // ------------------------------------------------------------
   // Read-status serial output
   // ------------------------------------------------------------
   logic read_active;
   logic [7:0] so_shift;
   logic [2:0] out_cnt;

   // Loads status after the opcode, shifts on falling edges
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         read_active <= 1'b0;
         so_shift <= '0;
         out_cnt <= '0;
         o_serial_out <= 1'b0;
         o_serial_out_oe <= 1'b0;
      end else if (ce_n_s) begin
         read_active <= 1'b0;
         o_serial_out_oe <= 1'b0;
      end else if (sck_rise && bit_cnt == BITS_OPCODE_LAST
                   && next_byte == READ_STATUS_CMD) begin
         read_active <= 1'b1;
         so_shift <= status_now;
         out_cnt <= '0;
      end else if (sck_fall && read_active) begin
         o_serial_out <= so_shift[7];
         o_serial_out_oe <= 1'b1;
         out_cnt <= out_cnt + 1'b1;
         so_shift <= (out_cnt == 3'h7) ? status_now : {so_shift[6:0], 1'b0};
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_busy_tracks_state;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      ##1 (busy_flag == (state != ST_IDLE));
   endproperty
   a_busy_tracks_state: assert property (p_busy_tracks_state)
      else $error("busy flag disagrees with engine state");

   property p_start_needs_latch;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      o_array_start |-> $past(write_enable_latch) && busy_flag;
   endproperty
   a_start_needs_latch: assert property (p_start_needs_latch)
      else $error("array operation started without write enable");

   property p_latch_clears_at_end;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      $fell(busy_flag) |-> !write_enable_latch;
   endproperty
   a_latch_clears_at_end: assert property (p_latch_clears_at_end)
      else $error("write enable latch survived completion");

   property p_whole_erase_unprotected;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      (o_array_start && o_array_req.op == OP_WHOLE_ERASE) |-> protect_bits == PROTECT_NONE;
   endproperty
   a_whole_erase_unprotected: assert property (p_whole_erase_unprotected)
      else $error("whole array erase with protect bits set");

   property p_no_protected_target;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      o_array_start |-> !$past(addr_protected);
   endproperty
   a_no_protected_target: assert property (p_no_protected_target)
      else $error("program or erase into protected region");

   property p_locked_bits_hold;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      status_locked |=> $stable(protect_bits) && $stable(status_lock_bit);
   endproperty
   a_locked_bits_hold: assert property (p_locked_bits_hold)
      else $error("locked status bits changed");

   property p_status_write_length;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      $rose(busy_flag) && state == ST_STATUS_WRITE |-> write_enable_latch [*8];
   endproperty
   a_status_write_length: assert property (p_status_write_length)
      else $error("status write ended too early");

   property p_whole_bytes_only;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      $rose(busy_flag) |-> $past(bit_cnt[2:0]) == 3'h0;
   endproperty
   a_whole_bytes_only: assert property (p_whole_bytes_only)
      else $error("write accepted on partial byte");

   property p_reserved_zero;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      sck_fall && read_active && (out_cnt == 3'h1 || out_cnt == 3'h2) |=> !o_serial_out;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved status bits nonzero");

endmodule : fsw_status_protect

/* tb/fsw_spi_master.sv */
// Behavioural serial master (mode 0) driving the flash pins
`timescale 1ns/1ps
module fsw_spi_master (
   input wire logic i_sys_clk,
   input wire logic i_serial_out,
   output logic o_spi_sck,
   output logic o_spi_ce_n,
   output logic o_sdi
);
   // Idle pins: clock low, deselected
   initial begin
      o_spi_sck = 1'b0;
      o_spi_ce_n = 1'b1;
      o_sdi = 1'b0;
   end

   // One frame: top nbits of data out, last eight bits seen kept
   task automatic xfer(input logic [39:0] data, input int nbits, output logic [7:0] rd);
      rd = 8'h00;
      @(negedge i_sys_clk);
      o_spi_ce_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         o_sdi = data[39-i];
         repeat (8) @(negedge i_sys_clk);
         o_spi_sck = 1'b1;
         rd = {rd[6:0], i_serial_out};
         repeat (8) @(negedge i_sys_clk);
         o_spi_sck = 1'b0;
      end
      repeat (8) @(negedge i_sys_clk);
      o_spi_ce_n = 1'b1;
      o_sdi = ~o_sdi; // Line not held once deselected
      repeat (8) @(negedge i_sys_clk);
   endtask : xfer
endmodule : fsw_spi_master

/* tb/flash_status_write_protect_tb.sv */
// Self-checking bench for the flash status and write-protect block
`timescale 1ns/1ps
module flash_status_write_protect_tb;
   import fsw_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic i_write_protect_n = 1'b0;
   logic i_array_done = 1'b0;
   logic spi_sck, spi_ce_n, sdi, serial_out, serial_out_oe, array_start;
   logic [7:0] rd;
   logic [18:0] a;
   bit ok;
   fsw_array_req_s array_req, req_q;
   fsw_status_s status;
   int n_fail = 0, compares = 0, pend = 0, n_start = 0, ns = 0;
   int m_lock = 0, m_prot = 0, m_wel = 0, n_oe = 0;
   logic [7:0] opc [6] = '{PROGRAM_CMD, SECTOR_ERASE_CMD, SECTOR_ERASE_ALT_CMD,
      BLOCK_ERASE_CMD, WHOLE_ARRAY_ERASE_CMD, WHOLE_ARRAY_ERASE_ALT_CMD};
   fsw_array_op_e ops [6] = '{OP_PROGRAM, OP_SECTOR_ERASE, OP_SECTOR_ERASE,
      OP_BLOCK_ERASE, OP_WHOLE_ERASE, OP_WHOLE_ERASE};
   int nbit [6] = '{40, 32, 32, 32, 8, 8};

   always #2.5 i_sys_clk = ~i_sys_clk;

   fsw_status_protect fsw_status_protect_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
      .i_spi_sck(spi_sck), .i_spi_ce_n(spi_ce_n), .i_serial_data_io(sdi),
      .i_write_protect_n(i_write_protect_n), .i_array_done(i_array_done),
      .o_serial_out(serial_out), .o_serial_out_oe(serial_out_oe),
      .o_array_start(array_start), .o_array_req(array_req), .o_status(status));
   fsw_spi_master fsw_spi_master_inst (.i_sys_clk(i_sys_clk), .i_serial_out(serial_out),
      .o_spi_sck(spi_sck), .o_spi_ce_n(spi_ce_n), .o_sdi(sdi));

   // Stand-in engine: done pulse ten cycles after each start
   always @(negedge i_sys_clk) begin
      i_array_done <= (pend == 1);
      if (array_start === 1'b1) begin
         pend = 10;
         n_start++;
         req_q = array_req;
      end else if (pend > 0) begin
         pend--;
      end
   end

   // Cycles with the serial output driven
   always @(negedge i_sys_clk) if (serial_out_oe === 1'b1) n_oe++;

   // ---------------------------------
   // Checking and bus helpers
   // ---------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic close_out();
      $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   task automatic cmd(input logic [7:0] c);
      fsw_spi_master_inst.xfer({c, 32'h0000_0000}, 8, rd);
   endtask : cmd

   task automatic write_status_cmd(input logic [7:0] v, input int n);
      fsw_spi_master_inst.xfer({WRITE_STATUS_CMD, v, 24'h00_0000}, n, rd);
   endtask : write_status_cmd

   // Reads status over the link and from the mirror against the model
   task automatic read_chk();
      logic [7:0] e;
      int o;
      e = {m_lock[0], 2'b00, m_prot[2:0], m_wel[0], 1'b0};
      o = n_oe;
      fsw_spi_master_inst.xfer({READ_STATUS_CMD, 32'h0000_0000}, 16, rd);
      chk(32'(rd), 32'(e));
      chk(32'(n_oe > o), 32'h0000_0001);
      chk(32'(serial_out_oe), 32'h0000_0000);
      chk(32'(status), 32'(e));
   endtask : read_chk

   task automatic wait_idle();
      int k;
      k = 0;
      while (status.busy_flag !== 1'b0 && k < 400) begin
         @(negedge i_sys_clk);
         k++;
      end
      if (k >= 400) begin
         n_fail++;
         close_out();
      end else begin
         repeat (3) @(negedge i_sys_clk);
      end
   endtask : wait_idle

   // Protected region per protect code and block
   function automatic bit prot_hit(int p, logic [18:0] ad);
      return (p >= 4) || (p == 3 && ad[18:16] >= 4) || (p == 2 && ad[18:16] >= 6)
         || (p == 1 && ad[18:16] == 7);
   endfunction : prot_hit

   // ---------------------------------
   // Main sequence
   // ---------------------------------
   initial begin
      void'($urandom(32'h86738fa9));
      repeat (5) @(negedge i_sys_clk);
      i_reset_n = 1'b1;
      repeat (10) @(negedge i_sys_clk);
      chk(32'(status), 32'h0000_0000);
      read_chk();
      write_status_cmd(8'h9c, 16);
      read_chk();
      cmd(WRITE_ENABLE_CMD);
      m_wel = 1;
      read_chk();
      cmd(WRITE_DISABLE_CMD);
      m_wel = 0;
      read_chk();
      $display("test done: latch");
      cmd(WRITE_ENABLE_CMD);
      m_wel = 1;
      write_status_cmd(8'h9c, 15);
      read_chk();
      write_status_cmd(8'hff, 16);
      chk(32'(status.busy_flag), 32'h0000_0001);
      wait_idle();
      m_lock = 1;
      m_prot = 7;
      m_wel = 0;
      read_chk();
      cmd(WRITE_ENABLE_CMD);
      m_wel = 1;
      write_status_cmd(8'h00, 16);
      wait_idle();
      read_chk();
      i_write_protect_n = 1'b1;
      write_status_cmd(8'h00, 16);
      wait_idle();
      m_lock = 0;
      m_prot = 0;
      m_wel = 0;
      read_chk();
      $display("test done: lock");
      for (int p = 0; p < 8; p++) begin
         cmd(WRITE_ENABLE_CMD);
         write_status_cmd(8'(p << 2), 16);
         wait_idle();
         m_prot = p;
         for (int j = 0; j < 6; j++) begin
            a = 19'($urandom_range(0, 32'h7ffff));
            ok = (j >= 4) ? (p == 0) : !prot_hit(p, a);
            ns = n_start;
            cmd(WRITE_ENABLE_CMD);
            fsw_spi_master_inst.xfer({opc[j], 5'h00, a, 8'h5a}, nbit[j], rd);
            wait_idle();
            chk(32'(n_start - ns), 32'(ok));
            if (ok) chk(32'(req_q.op), 32'(ops[j]));
            if (ok && j < 4) chk(32'({req_q.addr, req_q.sector, req_q.block}),
               32'({5'h00, a, a[18:12], a[18:16]}));
            m_wel = ok ? 0 : 1;
            read_chk();
         end
         $display("test done: protect code %0d", p);
      end
      close_out();
   end
endmodule : flash_status_write_protect_tb
